// [rtl/ismz_pkg.sv]
// Shared constants and carrier types of the status/mask zero block
package ismz_pkg;

    // Register map; status read and mask write share one address
    localparam int          ISMZ_ADDR_W      = 3;
    localparam logic [2:0]  ISMZ_OFF_STATUS  = 3'h0;
    localparam logic [2:0]  ISMZ_OFF_CLEAR   = 3'h1;

    // Bit positions of status and mask
    localparam int          ISMZ_B_NBA       = 7;
    localparam int          ISMZ_B_GIE       = 7;
    localparam int          ISMZ_B_SBO       = 6;
    localparam int          ISMZ_B_NL        = 5;
    localparam int          ISMZ_B_EOS       = 4;
    localparam int          ISMZ_B_IFC       = 3;
    localparam int          ISMZ_B_ATN       = 2;
    localparam int          ISMZ_B_SYNC      = 0;

    // Reset values and field masks
    localparam logic [7:0]  ISMZ_MASK_RST    = 8'h80;
    localparam logic [7:0]  ISMZ_MASK_WR     = 8'hed;
    localparam logic [7:0]  ISMZ_IRQ_BITS    = 8'h4d;
    localparam logic [7:0]  ISMZ_ZERO        = 8'h00;
    localparam logic [6:0]  ISMZ_NL_CHAR     = 7'h0a;
    localparam logic        ISMZ_IFC_IDLE    = 1'b1;

    // Register port request
    typedef struct packed {
        logic [ISMZ_ADDR_W-1:0] addr;
        logic [7:0]             wdata;
        logic                   wr;
        logic                   rd;
    } ismz_bus_type;

    // Messages and events from the surrounding interface logic
    typedef struct packed {
        logic cmd_out_wr;
        logic nbaf;
        logic ntnl;
        logic sids;
        logic strs;
        logic spas;
        logic poll_mode_wr;
        logic lacs;
        logic acds;
        logic reos;
        logic clr_interface_clear_event;
        logic atn_evt;
        logic sync_evt;
        logic rd_clr_inhibit;
    } ismz_evt_type;

endpackage : ismz_pkg

// [rtl/ismz_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ismz_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      lvl
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_r  <= RST_VAL;
            s2_r  <= RST_VAL;
            s3_r  <= RST_VAL;
            lvl_r <= RST_VAL;
        end else begin
            s1_r  <= pin;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= (s2_r == s3_r) ? s3_r : lvl_r;
        end
    end

    assign lvl = lvl_r;

endmodule : ismz_sync

// [rtl/ismz_flag.sv]
// One status bit with set priority and read hold-off
`timescale 1ns/1ps
module ismz_flag (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic set,
    input  wire logic clr,
    input  wire logic hold,
    output logic      q
);
    logic q_r;
    logic pend_r;
    wire  req   = set | pend_r;
    wire  apply = req & ~hold;
    wire  q_nxt = apply ? 1'b1 : (clr ? 1'b0 : q_r);

    // Set parks while held so a read never sees a half-set bit
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q_r    <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            q_r    <= q_nxt;
            pend_r <= req & hold;
        end
    end

    assign q = q_r;

endmodule : ismz_flag

// [rtl/ismz_top.sv]
// Interrupt status zero and mask zero with interrupt output
`timescale 1ns/1ps
module ismz_top (
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    input  wire ismz_pkg::ismz_bus_type bus,
    input  wire ismz_pkg::ismz_evt_type evt,
    input  wire logic [7:0]             dio_byte,
    input  wire logic [7:0]             eos_char,
    input  wire logic                   ifc_pin_n,
    output logic [7:0]                  rd_data,
    output logic                        irq_n,
    output logic                        nba_msg,
    output logic                        end_accept
);

    // Address match, shared by read and write decode
    function automatic logic addr_hit(
        input logic [ismz_pkg::ISMZ_ADDR_W-1:0] a,
        input logic [ismz_pkg::ISMZ_ADDR_W-1:0] off
    );
        addr_hit = (a == off);
    endfunction : addr_hit

    logic [7:0] mask_r;
    logic [7:0] rd_data_r;
    logic       irq_n_r;
    logic       end_accept_r;
    logic       spas_d_r;
    logic       ifc_d_r;
    logic [7:0] isr;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic       ifc_lvl_n;

    // Bus decode
    wire hit_status = addr_hit(bus.addr, ismz_pkg::ISMZ_OFF_STATUS);
    wire hit_clear  = addr_hit(bus.addr, ismz_pkg::ISMZ_OFF_CLEAR);
    wire rd_status  = bus.rd & hit_status;
    wire wr_mask    = bus.wr & hit_status;
    wire wr_clear   = bus.wr & hit_clear;
    wire rd_clr     = rd_status & ~evt.rd_clr_inhibit;
    wire [7:0] w1c  = wr_clear ? (bus.wdata & ismz_pkg::ISMZ_IRQ_BITS)
                               : ismz_pkg::ISMZ_ZERO;

    // Mask fields
    wire gie      = mask_r[ismz_pkg::ISMZ_B_GIE];
    wire sbo_en   = mask_r[ismz_pkg::ISMZ_B_SBO];
    wire nl_en    = mask_r[ismz_pkg::ISMZ_B_NL];

    // Acceptor side terms
    wire acc      = evt.lacs & evt.acds;
    wire nl_byte  = (dio_byte[6:0] == ismz_pkg::ISMZ_NL_CHAR);
    wire eos_cmp  = evt.reos & (dio_byte == eos_char);
    wire eos_hit  = acc & (eos_cmp | (nl_en & nl_byte));
    wire spas_up  = evt.spas & ~spas_d_r;
    wire ifc_rise = ~ifc_lvl_n & ifc_d_r;

    // IFC arrives from the bus pin, so it is synchronised
    ismz_sync #(
        .RST_VAL (ismz_pkg::ISMZ_IFC_IDLE)
    ) u_ifc_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pin     (ifc_pin_n),
        .lvl     (ifc_lvl_n)
    );

    // Set terms per status bit
    assign set_v[ismz_pkg::ISMZ_B_NBA]  = evt.cmd_out_wr;
    assign set_v[ismz_pkg::ISMZ_B_SBO]  = sbo_en & spas_up;
    assign set_v[ismz_pkg::ISMZ_B_NL]   = acc & nl_byte;
    assign set_v[ismz_pkg::ISMZ_B_EOS]  = eos_hit;
    assign set_v[ismz_pkg::ISMZ_B_IFC]  = ifc_rise;
    assign set_v[ismz_pkg::ISMZ_B_ATN]  = evt.atn_evt;
    assign set_v[1]                     = 1'b0;
    assign set_v[ismz_pkg::ISMZ_B_SYNC] = evt.sync_evt;

    // Clear terms; a set in the same cycle wins unless a status read holds it off
    assign clr_v[ismz_pkg::ISMZ_B_NBA]  = evt.nbaf
                                        | (evt.ntnl & evt.sids)
                                        | evt.strs;
    assign clr_v[ismz_pkg::ISMZ_B_SBO]  = evt.poll_mode_wr | ~evt.spas
                                        | w1c[ismz_pkg::ISMZ_B_SBO];
    assign clr_v[ismz_pkg::ISMZ_B_NL]   = acc & ~nl_byte;
    assign clr_v[ismz_pkg::ISMZ_B_EOS]  = (acc & ~eos_hit)
                                        | (~evt.reos & ~nl_en);
    assign clr_v[ismz_pkg::ISMZ_B_IFC]  = rd_clr | evt.clr_interface_clear_event
                                        | w1c[ismz_pkg::ISMZ_B_IFC];
    assign clr_v[ismz_pkg::ISMZ_B_ATN]  = rd_clr
                                        | w1c[ismz_pkg::ISMZ_B_ATN];
    assign clr_v[1]                     = 1'b0;
    assign clr_v[ismz_pkg::ISMZ_B_SYNC] = w1c[ismz_pkg::ISMZ_B_SYNC];

    // Status looks at the mask only through the SBO and NL enables; reads hold off sets
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            ismz_flag u_flag (
                .sys_clk (sys_clk),
                .rstn    (rstn),
                .set     (set_v[gi]),
                .clr     (clr_v[gi]),
                .hold    (rd_status),
                .q       (isr[gi])
            );
        end
    endgenerate

    // Interrupt request and read data next values
    wire [7:0] irq_src  = isr & mask_r & ismz_pkg::ISMZ_IRQ_BITS;
    wire       irq_act  = gie & (|irq_src);
    wire       irq_nxt  = ~irq_act;
    wire [7:0] rd_nxt   = rd_status ? isr : ismz_pkg::ISMZ_ZERO;
    wire [7:0] mask_nxt = wr_mask ? (bus.wdata & ismz_pkg::ISMZ_MASK_WR)
                                  : mask_r;

    // Mask cannot be read back, so software must write it whole
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mask_r <= ismz_pkg::ISMZ_MASK_RST;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // Read data stands for exactly one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_r <= ismz_pkg::ISMZ_ZERO;
        end else begin
            rd_data_r <= rd_nxt;
        end
    end

    // Registered so the pin never glitches on decode
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_n_r      <= 1'b1;
            end_accept_r <= 1'b0;
        end else begin
            irq_n_r      <= irq_nxt;
            end_accept_r <= eos_hit;
        end
    end

    // Edge history for poll and IFC detection
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            spas_d_r <= 1'b0;
            ifc_d_r  <= ismz_pkg::ISMZ_IFC_IDLE;
        end else begin
            spas_d_r <= evt.spas;
            ifc_d_r  <= ifc_lvl_n;
        end
    end

    assign rd_data    = rd_data_r;
    assign irq_n      = irq_n_r;
    assign nba_msg    = isr[ismz_pkg::ISMZ_B_NBA];
    assign end_accept = end_accept_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    mask_write_a: assert property (
        wr_mask |=> mask_r == ($past(bus.wdata) & 8'hed)
    ) else $error("mask write not stored with bits 4 and 1 zero");

    mask_hold_a: assert property (
        !wr_mask |=> $stable(mask_r)
    ) else $error("mask changed without a write");

    gie_gate_a: assert property (
        !gie ##1 !gie |-> irq_n
    ) else $error("interrupt asserted with global enable clear");

    irq_assert_a: assert property (
        (gie && (|(isr & mask_r & 8'h4d))) |=> !irq_n
    ) else $error("enabled status did not assert interrupt");

    irq_idle_a: assert property (
        !(|(isr & mask_r & 8'h4d)) |=> irq_n
    ) else $error("interrupt asserted with no enabled status");

    read_data_a: assert property (
        rd_status |=> rd_data == $past(isr)
    ) else $error("status read returned wrong value");

    read_idle_a: assert property (
        !bus.rd |=> rd_data == 8'h00
    ) else $error("read data not zero outside read slot");

    sync_holdoff_a: assert property (
        (rd_status && evt.sync_evt && !isr[0]) ##1 !rd_status
        |-> !isr[0] ##1 isr[0]
    ) else $error("held-off status bit not set after read");

    nba_set_a: assert property (
        (evt.cmd_out_wr && !rd_status) |=> nba_msg
    ) else $error("output register write did not set nba");

    nba_clear_a: assert property (
        (evt.strs && !evt.cmd_out_wr && !rd_status && !$past(rd_status))
        |=> !nba_msg
    ) else $error("nba not cleared in transfer state");

    sbo_set_a: assert property (
        (sbo_en && $rose(evt.spas) && !rd_status) |=> isr[6]
    ) else $error("poll did not set status byte out");

    atn_nomask_a: assert property (
        (evt.atn_evt && !mask_r[2] && !rd_status) |=> isr[2]
    ) else $error("masked event not recorded in status");

    ifc_rdclr_a: assert property (
        (rd_status && !evt.rd_clr_inhibit) |=> !isr[3]
    ) else $error("status read did not clear ifc event");

    nl_end_a: assert property (
        (nl_en && acc && !rd_status && dio_byte[6:0] == 7'h0a)
        |=> end_accept && isr[4]
    ) else $error("newline not taken as end of string");

    irq_cover_c: cover property (
        gie && !irq_n
    );

    holdoff_cover_c: cover property (
        rd_status && evt.sync_evt ##1 !rd_status ##1 isr[0]
    );

    sbo_cover_c: cover property (
        sbo_en && $rose(evt.spas) ##1 isr[6]
    );

    w1c_cover_c: cover property (
        wr_clear && isr[0] ##1 !isr[0]
    );

endmodule : ismz_top

// [dv/ismz_host.sv]
// Host model driving the register port of the status/mask zero block
`timescale 1ns/1ps
module ismz_host (
    input  wire logic              sys_clk,
    output ismz_pkg::ismz_bus_type bus
);
    initial bus = '0;
    // Mask is write-only, so the host always writes it whole
    task automatic acc(input logic [2:0] a, input logic [7:0] d,
                       input logic w);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
        @(posedge sys_clk);
        // Released address and data lines flip, so a stale value cannot pass unseen
        bus <= '{addr: ~a, wdata: ~d, wr: 1'h0, rd: 1'h0};
    endtask : acc
endmodule : ismz_host

// [dv/test_ismz_top.sv]
// Self-checking bench of the status/mask zero block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_ismz_top;
    logic                   sys_clk    = 1'h0;
    logic                   rstn       = 1'h0;
    ismz_pkg::ismz_bus_type bus;
    ismz_pkg::ismz_evt_type evt        = '0;
    ismz_pkg::ismz_evt_type clr_k[3];
    logic [7:0]             dio_byte   = 8'h00;
    logic [7:0]             eos_char   = 8'h0d;
    logic                   ifc_pin_n  = 1'h1;
    logic [7:0]             rd_data;
    logic                   irq_n;
    logic                   nba_msg;
    logic                   end_accept;
    logic                   rd_d       = 1'h0;
    logic [7:0]             e;
    logic [7:0]             ec;
    logic [7:0]             exp_q[$];
    int                     fails      = 0;
    int                     n_compared = 0;
    int                     cyc        = 0;
    int                     k;
    int                     seed       = 32'h38df;

    ismz_top ismz_top_inst (.sys_clk(sys_clk), .rstn(rstn), .bus(bus),
        .evt(evt), .dio_byte(dio_byte), .eos_char(eos_char),
        .ifc_pin_n(ifc_pin_n), .rd_data(rd_data), .irq_n(irq_n),
        .nba_msg(nba_msg), .end_accept(end_accept));
    ismz_host ismz_host_inst (.sys_clk(sys_clk), .bus(bus));

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic test_done;
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        ismz_host_inst.acc(a, d, 1'h1);
    endtask : wr
    task automatic rd(input logic [7:0] x);
        exp_q.push_back(x);
        ismz_host_inst.acc(ismz_pkg::ISMZ_OFF_STATUS, 8'h00, 1'h0);
    endtask : rd
    task automatic ev(input ismz_pkg::ismz_evt_type m);
        @(posedge sys_clk);
        evt <= evt | m;
        @(posedge sys_clk);
        evt <= evt & ~m;
        #1;
    endtask : ev
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            `CHK(rd_data, e)
        end
        rd_d <= bus.rd;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            test_done();
        end
    end

    initial begin
        clr_k[0] = '{default: 1'h0, nbaf: 1'h1};
        clr_k[1] = '{default: 1'h0, ntnl: 1'h1, sids: 1'h1};
        clr_k[2] = '{default: 1'h0, strs: 1'h1};
        repeat (8) @(posedge sys_clk);
        rstn <= 1'h1;
        tick(1);
        `CHK(irq_n, 1'h1)
        rd(8'h00);
        $display("test reset done");
        ev('{default: 1'h0, sync_evt: 1'h1});
        rd(8'h01);
        tick(2);
        `CHK(irq_n, 1'h1)
        wr(3'h0, 8'h01);
        tick(2);
        `CHK(irq_n, 1'h1)
        wr(3'h0, 8'h81);
        tick(2);
        `CHK(irq_n, 1'h0)
        wr(3'h1, 8'h01);
        tick(2);
        `CHK(irq_n, 1'h1)
        rd(8'h00);
        $display("test sync mask done");
        for (k = 0; k < 3; k++) begin
            ev('{default: 1'h0, cmd_out_wr: 1'h1});
            `CHK(nba_msg, 1'h1)
            rd(8'h80);
            ev(clr_k[k]);
            `CHK(nba_msg, 1'h0)
        end
        $display("test nba done");
        wr(3'h0, 8'h88);
        evt.rd_clr_inhibit <= 1'h1;
        ifc_pin_n <= 1'h0;
        tick(8);
        ifc_pin_n <= 1'h1;
        `CHK(irq_n, 1'h0)
        rd(8'h08);
        rd(8'h08);
        ev('{default: 1'h0, clr_interface_clear_event: 1'h1});
        rd(8'h00);
        evt.rd_clr_inhibit <= 1'h0;
        ifc_pin_n <= 1'h0;
        tick(8);
        ifc_pin_n <= 1'h1;
        rd(8'h08);
        rd(8'h00);
        $display("test ifc done");
        // Events in the very cycle of a status read
        wr(3'h0, 8'h84);
        fork
            rd(8'h00);
            ev('{default: 1'h0, atn_evt: 1'h1, sync_evt: 1'h1});
        join
        tick(1);
        rd(8'h05);
        wr(3'h1, 8'h01);
        rd(8'h00);
        $display("test hold-off done");
        wr(3'h0, 8'hc0);
        evt.spas <= 1'h1;
        tick(3);
        `CHK(irq_n, 1'h0)
        rd(8'h40);
        ev('{default: 1'h0, poll_mode_wr: 1'h1});
        rd(8'h00);
        evt.spas <= 1'h0;
        tick(1);
        evt.spas <= 1'h1;
        tick(2);
        rd(8'h40);
        evt.spas <= 1'h0;
        tick(2);
        rd(8'h00);
        $display("test status byte out done");
        wr(3'h0, 8'ha0);
        dio_byte <= 8'h0a;
        ev('{default: 1'h0, lacs: 1'h1, acds: 1'h1});
        `CHK(end_accept, 1'h1)
        rd(8'h30);
        // Low seven bits never match a newline
        ec = {2'h1, 6'($random(seed))};
        eos_char <= ec;
        dio_byte <= ec;
        evt.reos <= 1'h1;
        ev('{default: 1'h0, lacs: 1'h1, acds: 1'h1});
        rd(8'h10);
        wr(3'h0, 8'hb2);
        tick(2);
        `CHK(irq_n, 1'h1)
        $display("test string end done");
        test_done();
    end
endmodule : test_ismz_top
